// *** include/meter_pkg.sv ***
// shared constants for the panel meter configuration and alarm block
// assumes a single 250 MHz clock and a 32-bit apb register bus
package meter_pkg;
  localparam int VAL_W = 32;
  localparam int MAX_POINTS = 21;
  localparam int ALARMS = 4;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int ONE_SECOND_NS = 1000000000;
  localparam int SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;
  localparam int TEST_STEP_NS = 500000000;
  localparam int TEST_STEP_CYCLES = TEST_STEP_NS / CLK_PERIOD_NS;
  localparam int DIGITS = 5;
  // ----------------------------------------
  // register word indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] IDX_LINK = 10'h000;
  localparam logic [9:0] IDX_ACCESS = 10'h001;
  localparam logic [9:0] IDX_TIME = 10'h002;
  localparam logic [9:0] IDX_SERVICE = 10'h003;
  localparam logic [9:0] IDX_CHAR = 10'h004;
  localparam logic [9:0] IDX_STATUS = 10'h005;
  localparam logic [9:0] IDX_SHOWN = 10'h006;
  localparam logic [9:0] IDX_ALARM0 = 10'h010;
  localparam logic [9:0] IDX_POINT0 = 10'h040;
  // ----------------------------------------
  // ranges and factory values
  // ----------------------------------------
  localparam logic signed [31:0] LEVEL_MIN = -32'sd19999;
  localparam logic signed [31:0] LEVEL_MAX = 32'sd99999;
  localparam logic signed [31:0] NODE_MAX = 32'sd247;
  localparam logic signed [31:0] ACCESS_MAX = 32'sd60000;
  localparam logic signed [31:0] RATE_MAX = 32'sd5;
  localparam logic signed [31:0] FRAME_MAX = 32'sd3;
  localparam logic signed [31:0] KIND_MAX = 32'sd5;
  localparam logic signed [31:0] FMT_MAX = 32'sd4;
  localparam logic signed [31:0] PCOUNT_MIN = 32'sd2;
  localparam logic signed [31:0] PCOUNT_MAX = 32'sd21;
  localparam logic signed [31:0] ZERO = 32'sd0;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [5:0] MINUTE_LAST = 6'h3b;
  localparam logic [2:0] FMT_FINEST = 3'h4;
  localparam logic [2:0] TIME_PRECISION = 3'h2;
  localparam logic signed [31:0] DEF_LOWER = 32'sd1000;
  localparam logic signed [31:0] DEF_UPPER = 32'sd2000;
  localparam logic signed [31:0] POINT_STEP = 32'sd100;
  localparam logic signed [31:0] HOUR_WEIGHT = 32'sd100;
  localparam logic [2:0] DEF_RATE = 3'h1;
  localparam logic [7:0] DEF_NODE = 8'h01;
  localparam logic [4:0] DEF_PCOUNT = 5'h15;
  typedef enum logic [2:0] {
    NORMAL_ON = 3'b000, NORMAL_OFF = 3'b001, WINDOW_ON = 3'b010,
    WINDOW_OFF = 3'b011, FORCED_ON = 3'b100, FORCED_OFF = 3'b101
  } alarm_kind_e;
  typedef enum logic [1:0] {
    EIGHT_NONE_TWO = 2'b00, EIGHT_EVEN_ONE = 2'b01,
    EIGHT_ODD_ONE = 2'b10, EIGHT_NONE_ONE = 2'b11
  } frame_e;
  function automatic logic [31:0] rate_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: rate_cycles = 32'(CLK_HZ / 4800);
      3'h1: rate_cycles = 32'(CLK_HZ / 9600);
      3'h2: rate_cycles = 32'(CLK_HZ / 19200);
      3'h3: rate_cycles = 32'(CLK_HZ / 38400);
      3'h4: rate_cycles = 32'(CLK_HZ / 57600);
      default: rate_cycles = 32'(CLK_HZ / 115200);
    endcase
  endfunction
endpackage

// *** core/meter_core.sv ***
// configuration store, rescaling, alarms and display control of a panel meter
// assumes an apb master on pclk and a measured value synchronous to pclk
`timescale 1ns/100ps
module meter_core
  import meter_pkg::*;
#(
  parameter int SECOND_TICKS = meter_pkg::SECOND_CYCLES,
  parameter int TEST_STEP_TICKS = meter_pkg::TEST_STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [meter_pkg::VAL_W-1:0] measured,
  input wire logic range_overflow,
  input wire logic time_mode,
  input wire logic test_button,
  output logic link_on,
  output logic [31:0] bit_cycles,
  output logic parity_on,
  output logic parity_odd,
  output logic two_stop,
  output logic [7:0] node_id,
  output logic password_on,
  output logic [meter_pkg::ALARMS-1:0] relay,
  output logic signed [meter_pkg::VAL_W-1:0] shown_value,
  output logic [2:0] shown_precision,
  output logic test_on,
  output logic [meter_pkg::DIGITS-1:0] test_digit,
  output logic char_fault
);
  import meter_pkg::*;

  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                              input logic signed [31:0] lo,
                                              input logic signed [31:0] hi);
    if (v > hi) begin
      clamp = hi;
    end else if (v < lo) begin
      clamp = lo;
    end else begin
      clamp = v;
    end
  endfunction

  // ----------------------------------------
  // stored settings
  // ----------------------------------------
  logic [2:0] rate_q;
  logic [1:0] frame_q;
  logic [7:0] node_q;
  logic [15:0] access_code_q;
  logic characteristic_enable_q;
  logic [4:0] pcount_q;
  logic [2:0] fmt_q;
  logic signed [31:0] measured_point_q [MAX_POINTS];
  logic signed [31:0] displayed_point_q [MAX_POINTS];
  alarm_kind_e alarm_kind_q [ALARMS];
  logic signed [31:0] lower_trip_level_q [ALARMS];
  logic signed [31:0] upper_trip_level_q [ALARMS];
  logic alarm_src_q [ALARMS];
  logic [4:0] hours_q;
  logic [5:0] minutes_q;
  logic [5:0] seconds_q;
  logic [31:0] sec_cnt_q;
  logic [31:0] step_cnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic [9:0] idx;
  logic wr;
  logic hit;
  logic [31:0] rdata_d;
  logic signed [31:0] wv;
  assign idx = paddr[11:2];
  assign wr = psel && penable && pwrite && pready_q;
  assign wv = signed'(pwdata);

  always_comb begin
    rdata_d = 32'h0;
    hit = 1'b1;
    if (idx == IDX_LINK) begin
      rdata_d = {16'h0, node_q, 2'h0, frame_q, 1'b0, rate_q};
    end else if (idx == IDX_ACCESS) begin
      rdata_d = {16'h0, access_code_q};
    end else if (idx == IDX_TIME) begin
      rdata_d = {18'h0, minutes_q, 3'h0, hours_q};
    end else if (idx == IDX_SERVICE) begin
      rdata_d = {30'h0, test_on, 1'b0};
    end else if (idx == IDX_CHAR) begin
      rdata_d = {13'h0, fmt_q, 3'h0, pcount_q, 7'h0, characteristic_enable_q};
    end else if (idx == IDX_STATUS) begin
      rdata_d = {24'h0, relay, 1'b0, password_on, link_on, char_fault};
    end else if (idx == IDX_SHOWN) begin
      rdata_d = shown_value;
    end else if (idx >= IDX_ALARM0 && idx < IDX_ALARM0 + 10'(4 * ALARMS)) begin
      case (idx[1:0])
        2'h0: rdata_d = {29'h0, alarm_kind_q[idx[3:2]]};
        2'h1: rdata_d = lower_trip_level_q[idx[3:2]];
        2'h2: rdata_d = upper_trip_level_q[idx[3:2]];
        default: rdata_d = {31'h0, alarm_src_q[idx[3:2]]};
      endcase
    end else if (idx >= IDX_POINT0 && idx < IDX_POINT0 + 10'(2 * MAX_POINTS)) begin
      rdata_d = idx[0] ? displayed_point_q[5'((idx - IDX_POINT0) >> 1)]
                       : measured_point_q[5'((idx - IDX_POINT0) >> 1)];
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !hit;
      if (psel && !penable) begin
        prdata_q <= pwrite ? 32'h0 : rdata_d;
      end
    end
  end

  // ----------------------------------------
  // settings store with clamping and restore
  // ----------------------------------------
  logic restore;
  assign restore = wr && idx == IDX_SERVICE && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q <= DEF_RATE;
      frame_q <= EIGHT_NONE_TWO;
      node_q <= DEF_NODE;
      access_code_q <= 16'h0;
      characteristic_enable_q <= 1'b0;
      pcount_q <= DEF_PCOUNT;
      fmt_q <= 3'h0;
      for (int i = 0; i < MAX_POINTS; i++) begin
        measured_point_q[i] <= 32'(i) * POINT_STEP;
        displayed_point_q[i] <= 32'(i) * POINT_STEP;
      end
      for (int a = 0; a < ALARMS; a++) begin
        alarm_kind_q[a] <= FORCED_OFF;
        lower_trip_level_q[a] <= DEF_LOWER;
        upper_trip_level_q[a] <= DEF_UPPER;
        alarm_src_q[a] <= 1'b0;
      end
    end else if (restore) begin
      rate_q <= DEF_RATE;
      frame_q <= EIGHT_NONE_TWO;
      node_q <= DEF_NODE;
      access_code_q <= 16'h0;
      characteristic_enable_q <= 1'b0;
      pcount_q <= DEF_PCOUNT;
      fmt_q <= 3'h0;
      for (int i = 0; i < MAX_POINTS; i++) begin
        measured_point_q[i] <= 32'(i) * POINT_STEP;
        displayed_point_q[i] <= 32'(i) * POINT_STEP;
      end
      for (int a = 0; a < ALARMS; a++) begin
        alarm_kind_q[a] <= FORCED_OFF;
        lower_trip_level_q[a] <= DEF_LOWER;
        upper_trip_level_q[a] <= DEF_UPPER;
        alarm_src_q[a] <= 1'b0;
      end
    end else if (wr) begin
      if (idx == IDX_LINK) begin
        rate_q <= 3'(clamp(signed'({29'h0, pwdata[2:0]}), ZERO, RATE_MAX));
        frame_q <= pwdata[5:4];
        node_q <= 8'(clamp(signed'({24'h0, pwdata[15:8]}), ZERO, NODE_MAX));
      end else if (idx == IDX_ACCESS) begin
        access_code_q <= 16'(clamp(wv, ZERO, ACCESS_MAX));
      end else if (idx == IDX_CHAR) begin
        characteristic_enable_q <= pwdata[0];
        pcount_q <= 5'(clamp(signed'({27'h0, pwdata[12:8]}), PCOUNT_MIN, PCOUNT_MAX));
        fmt_q <= 3'(clamp(signed'({29'h0, pwdata[18:16]}), ZERO, FMT_MAX));
      end else if (idx >= IDX_ALARM0 && idx < IDX_ALARM0 + 10'(4 * ALARMS)) begin
        case (idx[1:0])
          2'h0: alarm_kind_q[idx[3:2]] <=
                  alarm_kind_e'(3'(clamp(signed'({29'h0, pwdata[2:0]}), ZERO, KIND_MAX)));
          2'h1: lower_trip_level_q[idx[3:2]] <= clamp(wv, LEVEL_MIN, LEVEL_MAX);
          2'h2: upper_trip_level_q[idx[3:2]] <= clamp(wv, LEVEL_MIN, LEVEL_MAX);
          default: alarm_src_q[idx[3:2]] <= pwdata[0];
        endcase
      end else if (idx >= IDX_POINT0 && idx < IDX_POINT0 + 10'(2 * MAX_POINTS)) begin
        if (idx[0]) begin
          displayed_point_q[5'((idx - IDX_POINT0) >> 1)] <= clamp(wv, LEVEL_MIN, LEVEL_MAX);
        end else begin
          measured_point_q[5'((idx - IDX_POINT0) >> 1)] <= clamp(wv, LEVEL_MIN, LEVEL_MAX);
        end
      end
    end
  end

  // ----------------------------------------
  // link settings out
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_on <= 1'b0;
      bit_cycles <= 32'h0;
      parity_on <= 1'b0;
      parity_odd <= 1'b0;
      two_stop <= 1'b0;
      node_id <= 8'h0;
      password_on <= 1'b0;
    end else begin
      link_on <= node_q != 8'h0;
      node_id <= node_q;
      bit_cycles <= rate_cycles(rate_q);
      parity_on <= frame_q == EIGHT_EVEN_ONE || frame_q == EIGHT_ODD_ONE;
      parity_odd <= frame_q == EIGHT_ODD_ONE;
      two_stop <= frame_q == EIGHT_NONE_TWO;
      password_on <= access_code_q != 16'h0;
    end
  end

  // ----------------------------------------
  // time of day
  // ----------------------------------------
  logic time_ok;
  assign time_ok = pwdata[4:0] <= HOUR_LAST && pwdata[13:8] <= MINUTE_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hours_q <= 5'h0;
      minutes_q <= 6'h0;
      seconds_q <= 6'h0;
      sec_cnt_q <= 32'h0;
    end else if (wr && idx == IDX_TIME && time_ok) begin
      hours_q <= pwdata[4:0];
      minutes_q <= pwdata[13:8];
      seconds_q <= 6'h0;
      sec_cnt_q <= 32'h0;
    end else if (sec_cnt_q == 32'(SECOND_TICKS - 1)) begin
      sec_cnt_q <= 32'h0;
      seconds_q <= seconds_q == MINUTE_LAST ? 6'h0 : seconds_q + 6'h1;
      if (seconds_q == MINUTE_LAST) begin
        minutes_q <= minutes_q == MINUTE_LAST ? 6'h0 : minutes_q + 6'h1;
        if (minutes_q == MINUTE_LAST) begin
          hours_q <= hours_q == HOUR_LAST ? 5'h0 : hours_q + 5'h1;
        end
      end
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // display self test
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_on <= 1'b0;
      test_digit <= '0;
      step_cnt_q <= 32'h0;
    end else if (wr && idx == IDX_SERVICE && pwdata[1]) begin
      test_on <= 1'b1;
      test_digit <= DIGITS'(1);
      step_cnt_q <= 32'h0;
    end else if (test_on && test_button) begin
      test_on <= 1'b0;
      test_digit <= '0;
    end else if (test_on) begin
      if (step_cnt_q == 32'(TEST_STEP_TICKS - 1)) begin
        step_cnt_q <= 32'h0;
        test_digit <= {test_digit[DIGITS-2:0], test_digit[DIGITS-1]};
      end else begin
        step_cnt_q <= step_cnt_q + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // rescaling characteristic
  // ----------------------------------------
  logic points_ok;
  logic signed [31:0] scaled;
  logic signed [63:0] dx;
  logic signed [63:0] dy;
  logic signed [63:0] dh;
  int seg;

  always_comb begin
    points_ok = 1'b1;
    seg = 0;
    for (int i = 0; i < MAX_POINTS - 1; i++) begin
      if (i < int'(pcount_q) - 1 && measured_point_q[i+1] <= measured_point_q[i]) begin
        points_ok = 1'b0;
      end
    end
    for (int i = 1; i < MAX_POINTS - 1; i++) begin
      if (i < int'(pcount_q) - 1 && measured >= measured_point_q[i]) begin
        seg = i;
      end
    end
    dx = 64'(measured) - 64'(measured_point_q[seg]);
    dy = 64'(displayed_point_q[seg+1]) - 64'(displayed_point_q[seg]);
    dh = 64'(measured_point_q[seg+1]) - 64'(measured_point_q[seg]);
    if (characteristic_enable_q && points_ok) begin
      scaled = 32'(64'(displayed_point_q[seg]) + (dx * dy) / dh);
    end else begin
      scaled = measured;
    end
  end

  // ----------------------------------------
  // display value and precision
  // ----------------------------------------
  logic signed [31:0] clock_value;
  logic [31:0] mag;
  logic [2:0] auto_prec;
  assign clock_value = signed'(32'(hours_q)) * HOUR_WEIGHT + signed'(32'(minutes_q));
  assign mag = scaled < 0 ? 32'(-scaled) : 32'(scaled);

  always_comb begin
    if (mag < 32'd10) begin
      auto_prec = 3'h4;
    end else if (mag < 32'd100) begin
      auto_prec = 3'h3;
    end else if (mag < 32'd1000) begin
      auto_prec = 3'h2;
    end else if (mag < 32'd10000) begin
      auto_prec = 3'h1;
    end else begin
      auto_prec = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shown_value <= '0;
      shown_precision <= 3'h0;
      char_fault <= 1'b0;
    end else begin
      char_fault <= !points_ok;
      if (time_mode) begin
        shown_value <= clock_value;
        shown_precision <= TIME_PRECISION;
      end else begin
        shown_value <= scaled;
        shown_precision <= fmt_q == FMT_FINEST ? auto_prec : fmt_q;
      end
    end
  end

  // ----------------------------------------
  // alarm outputs; overflow is deliberately not an input here
  // ----------------------------------------
  logic signed [31:0] ax [ALARMS];

  always_comb begin
    for (int a = 0; a < ALARMS; a++) begin
      ax[a] = alarm_src_q[a] ? clock_value : scaled;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay <= '0;
    end else begin
      for (int a = 0; a < ALARMS; a++) begin
        case (alarm_kind_q[a])
          FORCED_ON: relay[a] <= 1'b1;
          FORCED_OFF: relay[a] <= 1'b0;
          default: begin
            if (lower_trip_level_q[a] > upper_trip_level_q[a]) begin
              relay[a] <= 1'b0;
            end else if (alarm_kind_q[a] == WINDOW_ON) begin
              relay[a] <= ax[a] >= lower_trip_level_q[a] && ax[a] <= upper_trip_level_q[a];
            end else if (alarm_kind_q[a] == WINDOW_OFF) begin
              relay[a] <= ax[a] < lower_trip_level_q[a] || ax[a] > upper_trip_level_q[a];
            end else if (ax[a] > upper_trip_level_q[a]) begin
              relay[a] <= alarm_kind_q[a] == NORMAL_ON;
            end else if (ax[a] < lower_trip_level_q[a]) begin
              relay[a] <= alarm_kind_q[a] == NORMAL_OFF;
            end
          end
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule

// *** bench/meter_checker.sv ***
// concurrent checks on the ports of the meter core
// assumes one clock pclk and async active-low presetn
`timescale 1ns/100ps
module meter_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [31:0] measured,
  input wire logic range_overflow,
  input wire logic time_mode,
  input wire logic test_button,
  input wire logic link_on,
  input wire logic [31:0] bit_cycles,
  input wire logic parity_on,
  input wire logic parity_odd,
  input wire logic two_stop,
  input wire logic [7:0] node_id,
  input wire logic [3:0] relay,
  input wire logic [2:0] shown_precision,
  input wire logic test_on,
  input wire logic [4:0] test_digit
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  link_off_a: assert property ($stable(node_id)[*2] |-> link_on == (node_id != 8'h00))
    else $error("link enable disagrees with node number");
  rate_set_a: assert property ($past(presetn) |-> bit_cycles inside
    {32'd52083, 32'd26041, 32'd13020, 32'd6510, 32'd4340, 32'd2170})
    else $error("bit period is not one of the six rates");
  frame_set_a: assert property ((two_stop |-> !parity_on) and (parity_odd |-> parity_on))
    else $error("frame outputs form no legal format");
  digit_onehot_a: assert property (test_on && $past(test_on) |-> $onehot(test_digit))
    else $error("test digit not one-hot");
  test_end_a: assert property (test_on && test_button && !(psel && penable) |-> ##[1:2] !test_on)
    else $error("button did not end display test");
  time_prec_a: assert property (time_mode[*3] |-> shown_precision == 3'h2)
    else $error("time display precision wrong");
  overflow_relay_a: assert property ((!psel && $stable(measured) && !time_mode)[*4]
    ##0 $changed(range_overflow) |=> $stable(relay))
    else $error("relay moved on overflow change");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_answer_a: assert property (psel && !penable |=> pready && penable)
    else $error("no zero-wait answer");
  slverr_qual_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property (test_on && test_button);
  cover property (pslverr);
  cover property ($rose(relay[0]));
  cover property (time_mode && !psel);
endmodule
bind meter_core meter_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .measured(measured),
  .range_overflow(range_overflow), .time_mode(time_mode), .test_button(test_button),
  .link_on(link_on), .bit_cycles(bit_cycles), .parity_on(parity_on),
  .parity_odd(parity_odd), .two_stop(two_stop), .node_id(node_id), .relay(relay),
  .shown_precision(shown_precision), .test_on(test_on), .test_digit(test_digit));

// *** bench/apb_host.sv ***
// apb master standing in for the keypad or serial master
// assumes pclk from the bench; waits for pready under a bound
`timescale 1ns/100ps
module apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic hung = 1'b0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 64);
    hung = !pready;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~{i, 2'b00};
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the meter core
// assumes apb_host as register master and the bound checker
`timescale 1ns/100ps
module tb_top;
  import meter_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pslverr, pready, range_overflow, time_mode, test_button;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, bit_cycles, rdv;
  logic signed [31:0] measured, shown_value;
  logic link_on, parity_on, parity_odd, two_stop, password_on, test_on, char_fault, errv;
  logic [7:0] node_id;
  logic [3:0] relay;
  logic [2:0] shown_precision;
  logic [4:0] test_digit;
  int miscompares = 0;
  int num_checks = 0;
  always #2 pclk = ~pclk;
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  meter_core #(.SECOND_TICKS(10), .TEST_STEP_TICKS(4)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .measured(measured),
    .range_overflow(range_overflow), .time_mode(time_mode), .test_button(test_button),
    .link_on(link_on), .bit_cycles(bit_cycles), .parity_on(parity_on),
    .parity_odd(parity_odd), .two_stop(two_stop), .node_id(node_id),
    .password_on(password_on), .relay(relay), .shown_value(shown_value),
    .shown_precision(shown_precision), .test_on(test_on), .test_digit(test_digit),
    .char_fault(char_fault));
  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d);
    host.xfer(w, i, d, rdv, errv);
    if (host.hung) begin
      miscompares++;
      complete_run();
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic link_cfg();
    int bps[6] = '{4800, 9600, 19200, 38400, 57600, 115200};
    for (int r = 0; r < 6; r++) begin
      bus(1'b1, IDX_LINK, 32'h100 | 32'((r % 4) << 4) | 32'(r));
      chk("bit_cycles", 32'(250000000 / bps[r]), bit_cycles);
      chk("parity_on", 32'(r % 4 == 1 || r % 4 == 2), parity_on);
      chk("parity_odd", 32'(r % 4 == 2), parity_odd);
      chk("two_stop", 32'(r % 4 == 0), two_stop);
    end
    bus(1'b1, IDX_LINK, 32'h0000_0007);
    chk("link_on", 32'h0, link_on);
    chk("bit_cycles", 32'd2170, bit_cycles);
    bus(1'b1, IDX_LINK, 32'h0000_ff00);
    chk("node_id", 32'hf7, node_id);
  endtask
  task automatic access_cfg();
    bus(1'b1, IDX_ACCESS, 32'h5);
    chk("password_on", 32'h1, password_on);
    bus(1'b1, IDX_ACCESS, 32'h0);
    chk("password_on", 32'h0, password_on);
    bus(1'b1, IDX_ACCESS, 32'hffff);
    bus(1'b0, IDX_ACCESS, 32'h0);
    chk("access_code", 32'd60000, rdv);
    bus(1'b0, 10'h3ff, 32'h0);
    chk("unmapped", 32'h1, {31'h0, errv});
  endtask
  task automatic rescale();
    int m[3] = '{50, -10, 300};
    int e[3] = '{500, -100, 2000};
    bus(1'b1, IDX_POINT0 + 10'h3, 32'd1000);
    bus(1'b1, IDX_POINT0 + 10'h5, 32'd1500);
    bus(1'b1, IDX_CHAR, 32'h0000_0301);
    for (int j = 0; j < 3; j++) begin
      measured <= 32'(m[j]);
      repeat (4) @(posedge pclk);
      chk("shown_value", 32'(e[j]), shown_value);
    end
    bus(1'b1, IDX_POINT0 + 10'h2, 32'h0);
    chk("char_fault", 32'h1, char_fault);
    chk("shown_value", 32'd300, shown_value);
  endtask
  task automatic restore();
    bus(1'b1, IDX_LINK, 32'h0000_0534);
    bus(1'b1, IDX_SERVICE, 32'h0);
    chk("node_id", 32'h5, node_id);
    bus(1'b1, IDX_SERVICE, 32'h1);
    chk("node_id", 32'h1, node_id);
    chk("bit_cycles", 32'd26041, bit_cycles);
    chk("two_stop", 32'h1, two_stop);
    chk("char_fault", 32'h0, char_fault);
    chk("relay", 32'h0, {28'h0, relay});
    bus(1'b0, IDX_ALARM0, 32'h0);
    chk("alarm_kind", 32'h5, rdv);
    bus(1'b0, IDX_ALARM0 + 10'h1, 32'h0);
    chk("lower_trip_level", 32'd1000, rdv);
    bus(1'b0, IDX_ALARM0 + 10'h2, 32'h0);
    chk("upper_trip_level", 32'd2000, rdv);
  endtask
  task automatic alarms();
    int k[11] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 5};
    int m[11] = '{2500, 1500, 500, 2500, 500, 1500, 500, 1500, 500, 500, 2500};
    int e[11] = '{1, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0};
    for (int j = 0; j < 11; j++) begin
      bus(1'b1, IDX_ALARM0, 32'(k[j]));
      measured <= 32'(m[j]);
      repeat (4) @(posedge pclk);
      chk("relay0", 32'(e[j]), {31'h0, relay[0]});
    end
    bus(1'b1, IDX_ALARM0, 32'h2);
    bus(1'b1, IDX_ALARM0 + 10'h1, 32'd3000);
    measured <= 32'sd1500;
    repeat (4) @(posedge pclk);
    chk("relay0", 32'h0, {31'h0, relay[0]});
    bus(1'b1, IDX_ALARM0 + 10'h1, 32'd1000);
    bus(1'b1, IDX_ALARM0, 32'h0);
    measured <= 32'sd2500;
    repeat (6) @(posedge pclk);
    range_overflow <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("relay0", 32'h1, {31'h0, relay[0]});
    measured <= 32'sd500;
    repeat (4) @(posedge pclk);
    chk("relay0", 32'h0, {31'h0, relay[0]});
    range_overflow <= 1'b0;
  endtask
  task automatic clock_and_format();
    bus(1'b1, IDX_CHAR, 32'h0004_1500);
    measured <= 32'sd5;
    repeat (4) @(posedge pclk);
    chk("precision", 32'h4, {29'h0, shown_precision});
    measured <= 32'sd50000;
    repeat (4) @(posedge pclk);
    chk("precision", 32'h0, {29'h0, shown_precision});
    bus(1'b1, IDX_TIME, 32'h0000_220c);
    bus(1'b1, IDX_TIME, 32'h0000_0018);
    bus(1'b1, IDX_TIME, 32'h0000_3c0c);
    bus(1'b0, IDX_TIME, 32'h0);
    chk("hours", 32'hc, rdv & 32'h1f);
    time_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("shown_time", 32'd1234, shown_value);
    chk("precision", 32'h2, {29'h0, shown_precision});
    bus(1'b1, IDX_ALARM0 + 10'h4, 32'h2);
    bus(1'b1, IDX_ALARM0 + 10'h7, 32'h1);
    chk("relay1", 32'h1, {31'h0, relay[1]});
    time_mode <= 1'b0;
  endtask
  task automatic self_test();
    bus(1'b1, IDX_SERVICE, 32'h2);
    chk("test_on", 32'h1, test_on);
    chk("digit", 32'h1, {31'h0, $onehot(test_digit)});
    repeat (2) @(posedge pclk);
    chk("digit", 32'h2, {27'h0, test_digit});
    test_button <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("test_on", 32'h0, test_on);
    test_button <= 1'b0;
  endtask
  initial begin
    measured = 32'sd0;
    range_overflow = 1'b0;
    time_mode = 1'b0;
    test_button = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    link_cfg();
    access_cfg();
    rescale();
    restore();
    alarms();
    clock_and_format();
    self_test();
    complete_run();
  end
endmodule
